// ### rtl/tfc_consts.svh
// Constants of the trace funnel control register bank: offsets, bit positions, resets.
// Assumes byte addresses relative to the global register base, 32-bit AXI4-Lite data.
`ifndef TFC_CONSTS_SVH
`define TFC_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TFC_ADDR_W 20
`define TFC_OFF_CONTROL 20'h3F100
`define TFC_OFF_CONFIG 20'h3F108
`define TFC_OFF_WRPTR 20'h3F110
`define TFC_OFF_RDPTR 20'h3F118
`define TFC_OFF_DATA0 20'h3F120
`define TFC_OFF_DATA7 20'h3F158
`define TFC_OFF_STUSER 20'h3F160
`define TFC_OFF_STENABLE 20'h3F168
`define TFC_DATA_WORDS 8

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define TFC_BIT_WE 31
`define TFC_BIT_CAPEN 20
`define TFC_BIT_IDLE 19
`define TFC_BIT_LOCK 18
`define TFC_BIT_OWNER 17
`define TFC_BIT_RDTRIG 16
`define TFC_BIT_PRST 15
`define TFC_BIT_WRAP 14
`define TFC_MODE_HI 9
`define TFC_MODE_LO 8
`define TFC_BIT_OFFCHIP 1
`define TFC_BIT_EN 0

// ----------------------------------------------------------------
// Reset values and responses
// ----------------------------------------------------------------
`define TFC_RST_WORD 32'h00000000
`define TFC_RESP_OKAY 2'h0
`define TFC_RESP_SLVERR 2'h2
`define TFC_DEF_DEPTH 256

`endif

// ### rtl/tfc_pkg.sv
// Types shared by the trace funnel control files.
// Assumes the constants header is compiled alongside.
package tfc_pkg;

  // Fill modes of the on-chip trace memory
  typedef enum logic [1:0]
  {
    TFC_FILL_WRAP = 2'h0,
    TFC_FILL_ONCE = 2'h1,
    TFC_FILL_RSV2 = 2'h2,
    TFC_FILL_RSV3 = 2'h3
  } tfc_fill_mode_type;

  // Trace memory read sequencer
  typedef enum logic [0:0]
  {
    TFC_RD_IDLE = 1'h0,
    TFC_RD_RUN = 1'h1
  } tfc_rd_state_type;

  // Lock owner encoding
  typedef enum logic [0:0]
  {
    TFC_OWNER_PROGRAM = 1'h0,
    TFC_OWNER_PROBE = 1'h1
  } tfc_owner_type;

endpackage : tfc_pkg

// ### rtl/tfc_trace_mem.sv
// On-chip trace memory: one write port, one read port, registered read data.
// Assumes a single clock; array contents are undefined after reset.
`timescale 1ns/100ps
module tfc_trace_mem
  import tfc_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 256,
  parameter int AW = $clog2(DEPTH)
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_q [DEPTH]; // Storage, no reset so it maps to RAM
  logic [WIDTH-1:0] rd_data_d; // Next read word

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Hold last word unless a read is asked for
  always_comb
  begin
    rd_data_d = rd_data;
    if (rd_en)
    begin
      rd_data_d = mem_q[rd_addr];
    end
  end

  // Read data register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= rd_data_d;
    end
  end

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  // Array write, kept reset-free for RAM inference
  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
  end

endmodule : tfc_trace_mem

// ### rtl/tfc_regs.sv
// Trace funnel global registers, trace word steering and the on-chip memory front end.
// Assumes an AXI4-Lite master on ref_clk and trace sources on the same clock.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
`include "tfc_consts.svh"
module tfc_regs
  import tfc_pkg::*;
#(
  parameter int DEPTH = `TFC_DEF_DEPTH,
  parameter int AW = $clog2(DEPTH)
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // AXI4-Lite write address and data
  input wire logic [`TFC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [`TFC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Processor trace source
  input wire logic trace_valid,
  input wire logic [31:0] trace_data,
  output logic trace_ready,
  // System trace source
  input wire logic sys_valid,
  input wire logic [31:0] sys_data,
  output logic sys_ready,
  // Off-chip trace port
  output logic offchip_valid,
  output logic [31:0] offchip_data,
  input wire logic offchip_ready
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Memory must be a power of two, hold the data window, fit the pointer
  if (DEPTH < 8 || DEPTH > (1 << 20) || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("tfc_regs: DEPTH must be a power of two from 8 to 2^20");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // Bus slave state
  logic awready_q, awready_d, wready_q, wready_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [`TFC_ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d, arready_q, arready_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  // Control and plain registers
  logic en_q, en_d, offchip_q, offchip_d, capen_q, capen_d, lock_q, lock_d;
  tfc_owner_type owner_q, owner_d; // Lock owner
  tfc_fill_mode_type mode_q, mode_d; // Fill mode select
  logic [31:0] config_q, config_d, stuser_q, stuser_d, stenable_q, stenable_d;
  logic [AW-1:0] rdptr_q, rdptr_d; // Read pointer
  // One-cycle commands from the bus group to the trace group
  logic rd_trig, ptr_rst, wp_wr;
  logic [AW-1:0] wp_wval; // Software value for the write pointer
  // Trace steering state
  logic [AW-1:0] wp_q, wp_d; // Write pointer
  logic wrapped_q, wrapped_d; // Memory wrapped flag
  logic mem_we_q, mem_we_d; // Word waiting for memory write
  logic [AW-1:0] mem_waddr_q, mem_waddr_d;
  logic [31:0] mem_wdata_q, mem_wdata_d;
  logic off_valid_q, off_valid_d;
  logic [31:0] off_data_q, off_data_d;
  logic trace_ready_q, trace_ready_d, sys_ready_q, sys_ready_d;
  logic sel_sys_q, sel_sys_d; // Alternates the two sources
  // Memory read sequencer
  tfc_rd_state_type rd_state_q, rd_state_d;
  logic [2:0] rd_cnt_q, rd_cnt_d, rd_slot_q, rd_slot_d;
  logic rd_cap_q, rd_cap_d;
  logic [31:0] data_q [`TFC_DATA_WORDS];
  logic [31:0] data_d [`TFC_DATA_WORDS];
  logic mem_rd_en;
  logic [AW-1:0] mem_rd_addr;
  logic [31:0] mem_rd_data;
  logic idle; // Nothing accepted is still in flight

  // Idle only when no word awaits memory or port
  assign idle = !mem_we_q && !off_valid_q;

  // ----------------------------------------------------------------
  // Decode and readback
  // ----------------------------------------------------------------
  // Known offset check; data slots sit on 8-byte steps
  function automatic logic hit(input logic [`TFC_ADDR_W-1:0] a);
    hit = (a == `TFC_OFF_CONTROL) || (a == `TFC_OFF_CONFIG) || (a == `TFC_OFF_WRPTR)
       || (a == `TFC_OFF_RDPTR) || (a == `TFC_OFF_STUSER) || (a == `TFC_OFF_STENABLE)
       || (a >= `TFC_OFF_DATA0 && a <= `TFC_OFF_DATA7 && a[2:0] == 3'h0);
  endfunction : hit

  // Register contents seen by software
  function automatic logic [31:0] rb(input logic [`TFC_ADDR_W-1:0] a);
    logic [`TFC_ADDR_W-1:0] diff;
    diff = a - `TFC_OFF_DATA0;
    rb = `TFC_RST_WORD;
    if (a == `TFC_OFF_CONTROL)
    begin
      // Write-enable, triggers and reserved bits read zero
      rb[`TFC_BIT_CAPEN] = capen_q;
      rb[`TFC_BIT_IDLE] = idle;
      rb[`TFC_BIT_LOCK] = lock_q;
      rb[`TFC_BIT_OWNER] = owner_q;
      rb[`TFC_BIT_WRAP] = wrapped_q;
      rb[`TFC_MODE_HI:`TFC_MODE_LO] = mode_q;
      rb[`TFC_BIT_OFFCHIP] = offchip_q;
      rb[`TFC_BIT_EN] = en_q;
    end
    else if (a == `TFC_OFF_CONFIG)
    begin
      rb = config_q;
    end
    else if (a == `TFC_OFF_WRPTR)
    begin
      rb[AW-1:0] = wp_q;
    end
    else if (a == `TFC_OFF_RDPTR)
    begin
      rb[AW-1:0] = rdptr_q;
    end
    else if (a == `TFC_OFF_STUSER)
    begin
      rb = stuser_q;
    end
    else if (a == `TFC_OFF_STENABLE)
    begin
      rb = stenable_q;
    end
    else if (hit(a))
    begin
      rb = data_q[diff[5:3]];
    end
  endfunction : rb

  // ----------------------------------------------------------------
  // Bus slave and control registers
  // ----------------------------------------------------------------
  // Next state of the bus, the control fields and the plain registers
  always_comb
  begin
    logic [31:0] mask;
    logic [31:0] m;
    mask = '0;
    m = '0;
    awready_d = awready_q;
    wready_d = wready_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    en_d = en_q;
    offchip_d = offchip_q;
    capen_d = capen_q;
    lock_d = lock_q;
    owner_d = owner_q;
    mode_d = mode_q;
    config_d = config_q;
    stuser_d = stuser_q;
    stenable_d = stenable_q;
    rdptr_d = rdptr_q;
    rd_trig = 1'b0;
    ptr_rst = 1'b0;
    wp_wr = 1'b0;
    wp_wval = '0;
    // Response handshakes retire first
    if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
    // Address and data are caught in either order
    if (s_axi_awvalid && awready_q)
    begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q)
    begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    // Both halves held: perform the write and answer
    if (aw_have_q && w_have_q && !bvalid_q)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = hit(awaddr_q) ? `TFC_RESP_OKAY : `TFC_RESP_SLVERR;
      mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
      m = (rb(awaddr_q) & ~mask) | (wdata_q & mask);
      unique case (awaddr_q)
        `TFC_OFF_CONTROL:
        begin
          // Fields change only with the write-enable bit in this write
          if (m[`TFC_BIT_WE])
          begin
            capen_d = m[`TFC_BIT_CAPEN];
            mode_d = tfc_fill_mode_type'(m[`TFC_MODE_HI:`TFC_MODE_LO]);
            offchip_d = m[`TFC_BIT_OFFCHIP];
            en_d = m[`TFC_BIT_EN];
            rd_trig = m[`TFC_BIT_RDTRIG];
            ptr_rst = m[`TFC_BIT_PRST];
            if (!lock_q)
            begin
              // Free lock: take both values as written
              lock_d = m[`TFC_BIT_LOCK];
              owner_d = tfc_owner_type'(m[`TFC_BIT_OWNER]);
            end
            else if (m[`TFC_BIT_OWNER] == owner_q)
            begin
              // Owner may release; others leave lock and owner alone
              lock_d = m[`TFC_BIT_LOCK];
            end
          end
        end
        `TFC_OFF_CONFIG: config_d = m;
        `TFC_OFF_WRPTR:
        begin
          wp_wr = 1'b1;
          wp_wval = m[AW-1:0];
        end
        `TFC_OFF_RDPTR: rdptr_d = m[AW-1:0];
        `TFC_OFF_STUSER: stuser_d = m;
        `TFC_OFF_STENABLE: stenable_d = m;
        default:
        begin
          // Data words are read-only; unknown offsets already answered
        end
      endcase
    end
    // Pointer reset also zeroes the read pointer
    if (ptr_rst)
    begin
      rdptr_d = '0;
    end
    // Read: answer on the edge the address is taken
    if (s_axi_arvalid && arready_q)
    begin
      rvalid_d = 1'b1;
      rdata_d = hit(s_axi_araddr) ? rb(s_axi_araddr) : `TFC_RST_WORD;
      rresp_d = hit(s_axi_araddr) ? `TFC_RESP_OKAY : `TFC_RESP_SLVERR;
    end
    // One write and one read under way at most
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  // Bus and control registers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= `TFC_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= `TFC_RESP_OKAY;
      rdata_q <= '0;
      arready_q <= 1'b0;
      en_q <= 1'b0;
      offchip_q <= 1'b0;
      capen_q <= 1'b0;
      lock_q <= 1'b0;
      owner_q <= TFC_OWNER_PROGRAM;
      mode_q <= TFC_FILL_WRAP;
      config_q <= `TFC_RST_WORD;
      stuser_q <= `TFC_RST_WORD;
      stenable_q <= `TFC_RST_WORD;
      rdptr_q <= '0;
    end
    else
    begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      arready_q <= arready_d;
      en_q <= en_d;
      offchip_q <= offchip_d;
      capen_q <= capen_d;
      lock_q <= lock_d;
      owner_q <= owner_d;
      mode_q <= mode_d;
      config_q <= config_d;
      stuser_q <= stuser_d;
      stenable_q <= stenable_d;
      rdptr_q <= rdptr_d;
    end
  end

  // ----------------------------------------------------------------
  // Trace steering and memory read sequencer
  // ----------------------------------------------------------------
  // Next state of the trace path
  always_comb
  begin
    logic take_proc;
    logic take_sys;
    logic [31:0] word;
    logic accept_ok;
    take_proc = trace_valid && trace_ready_q;
    take_sys = sys_valid && sys_ready_q;
    word = take_sys ? sys_data : trace_data;
    accept_ok = 1'b0;
    wp_d = wp_q;
    wrapped_d = wrapped_q;
    mem_we_d = 1'b0;
    mem_waddr_d = mem_waddr_q;
    mem_wdata_d = mem_wdata_q;
    off_valid_d = off_valid_q && !offchip_ready;
    off_data_d = off_data_q;
    rd_state_d = rd_state_q;
    rd_cnt_d = rd_cnt_q;
    rd_slot_d = rd_slot_q;
    rd_cap_d = 1'b0;
    data_d = data_q;
    mem_rd_en = 1'b0;
    mem_rd_addr = '0;
    // Software pointer write, then the reset command
    if (wp_wr)
    begin
      wp_d = wp_wval;
    end
    if (ptr_rst)
    begin
      wp_d = '0;
      wrapped_d = 1'b0;
    end
    // Route the accepted word; a wrap set beats a same-cycle clear
    if (take_proc || take_sys)
    begin
      if (offchip_q)
      begin
        off_valid_d = 1'b1;
        off_data_d = word;
      end
      else
      begin
        mem_we_d = 1'b1;
        mem_waddr_d = wp_d;
        mem_wdata_d = word;
        wp_d = wp_d + AW'(1);
        if (mem_waddr_d == AW'(DEPTH - 1))
        begin
          wrapped_d = 1'b1;
        end
      end
    end
    // Stop on disable, or once full in fill-once mode unless routed off-chip
    accept_ok = en_d && !(mode_d == TFC_FILL_ONCE && wrapped_d && !offchip_d);
    if (offchip_d && off_valid_d)
    begin
      accept_ok = 1'b0;
    end
    // System words only while capture is allowed
    sel_sys_d = capen_d ? !sel_sys_q : 1'b0;
    trace_ready_d = accept_ok && !sel_sys_d;
    sys_ready_d = accept_ok && sel_sys_d;
    // Land the word fetched last cycle in its data slot
    if (rd_cap_q)
    begin
      data_d[rd_slot_q] = mem_rd_data;
    end
    // Fetch eight words from the read pointer onward
    unique case (rd_state_q)
      TFC_RD_IDLE:
      begin
        if (rd_trig)
        begin
          rd_state_d = TFC_RD_RUN;
          rd_cnt_d = 3'h0;
        end
      end
      TFC_RD_RUN:
      begin
        mem_rd_en = 1'b1;
        mem_rd_addr = rdptr_q + AW'(rd_cnt_q);
        rd_cap_d = 1'b1;
        rd_slot_d = rd_cnt_q;
        rd_cnt_d = rd_cnt_q + 3'h1;
        if (rd_cnt_q == 3'h7)
        begin
          rd_state_d = TFC_RD_IDLE;
        end
      end
    endcase
  end

  // Trace path registers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_q <= '0;
      wrapped_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_waddr_q <= '0;
      mem_wdata_q <= '0;
      off_valid_q <= 1'b0;
      off_data_q <= '0;
      trace_ready_q <= 1'b0;
      sys_ready_q <= 1'b0;
      sel_sys_q <= 1'b0;
      rd_state_q <= TFC_RD_IDLE;
      rd_cnt_q <= 3'h0;
      rd_slot_q <= 3'h0;
      rd_cap_q <= 1'b0;
      data_q <= '{default: '0};
    end
    else
    begin
      wp_q <= wp_d;
      wrapped_q <= wrapped_d;
      mem_we_q <= mem_we_d;
      mem_waddr_q <= mem_waddr_d;
      mem_wdata_q <= mem_wdata_d;
      off_valid_q <= off_valid_d;
      off_data_q <= off_data_d;
      trace_ready_q <= trace_ready_d;
      sys_ready_q <= sys_ready_d;
      sel_sys_q <= sel_sys_d;
      rd_state_q <= rd_state_d;
      rd_cnt_q <= rd_cnt_d;
      rd_slot_q <= rd_slot_d;
      rd_cap_q <= rd_cap_d;
      data_q <= data_d;
    end
  end

  // ----------------------------------------------------------------
  // Trace memory and outputs
  // ----------------------------------------------------------------
  // Memory write lags acceptance one cycle; idle covers that gap
  tfc_trace_mem #(.WIDTH(32), .DEPTH(DEPTH), .AW(AW)) u_mem
  (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .wr_en(mem_we_q),
    .wr_addr(mem_waddr_q),
    .wr_data(mem_wdata_q),
    .rd_en(mem_rd_en),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data)
  );

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign trace_ready = trace_ready_q;
  assign sys_ready = sys_ready_q;
  assign offchip_valid = off_valid_q;
  assign offchip_data = off_data_q;

endmodule : tfc_regs

// ### sim/tfc_regs_checker.sv
// Port checker for the trace funnel register bank.
// Assumes binding to tfc_regs, one clock, asynchronous active-low reset.
`timescale 1ns/100ps
`include "tfc_consts.svh"
module tfc_regs_checker
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Read channel
  input wire logic [`TFC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Trace side
  input wire logic trace_valid,
  input wire logic trace_ready,
  input wire logic sys_valid,
  input wire logic sys_ready,
  input wire logic offchip_valid,
  input wire logic [31:0] offchip_data,
  input wire logic offchip_ready
);
  logic [`TFC_ADDR_W-1:0] ra_q; // Address of the read in flight
  logic [`TFC_ADDR_W-1:0] ra_d;
  logic acc; // A trace word taken this cycle
  logic ctl; // Control readback on the bus
  assign acc = (trace_valid && trace_ready) || (sys_valid && sys_ready);
  assign ctl = s_axi_rvalid && (ra_q == `TFC_OFF_CONTROL);
  // Latch the address when the read is taken
  always_comb
  begin
    ra_d = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ra_q;
  end
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      ra_q <= '0;
    else
      ra_q <= ra_d;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_reserved_zero: assert property (ctl |->
    s_axi_rdata[30:21] == 10'h000 && s_axi_rdata[13:10] == 4'h0)
    else $error("reserved control bits not zero");
  a_we_not_stored: assert property (ctl |-> !s_axi_rdata[31])
    else $error("write enable bit read back");
  a_unmapped_err: assert property (s_axi_rvalid && ra_q[2] |->
    s_axi_rresp == `TFC_RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("odd word read not refused");
  a_mapped_ok: assert property (s_axi_rvalid && ra_q[2:0] == 3'h0
    && ra_q >= `TFC_OFF_CONTROL && ra_q <= `TFC_OFF_STENABLE |-> s_axi_rresp == `TFC_RESP_OKAY)
    else $error("mapped register read refused");
  a_idle_quiet: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == `TFC_OFF_CONTROL && !offchip_valid && !$past(acc) |=> s_axi_rdata[19])
    else $error("idle flag low with nothing pending");
  a_port_hold: assert property (offchip_valid && !offchip_ready |=>
    offchip_valid && $stable(offchip_data))
    else $error("off-chip word dropped before taken");
  a_src_single: assert property (!(trace_ready && sys_ready))
    else $error("both trace sources served at once");
  a_sys_alternate: assert property (sys_ready |=> !sys_ready)
    else $error("system source served twice in a row");
  c_ctl_read: cover property (ctl);
  c_sys_word: cover property (sys_valid && sys_ready);
  c_port_word: cover property (offchip_valid && offchip_ready);
endmodule : tfc_regs_checker

bind tfc_regs tfc_regs_checker tfc_regs_checker_inst (.*);

// ### sim/tfc_trace_partner.sv
// Trace source pair and off-chip sink standing on the far side.
// Assumes the bench changes go and stall just after rising edges.
`timescale 1ns/100ps
module tfc_trace_partner
(
  // Clock, reset and bench knobs
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic go,
  input wire logic stall,
  // Trace sources, both offering the same running count
  output logic trace_valid,
  output logic [31:0] trace_data,
  input wire logic trace_ready,
  output logic sys_valid,
  output logic [31:0] sys_data,
  input wire logic sys_ready,
  // Off-chip sink
  output logic offchip_ready
);
  logic [31:0] cnt_q; // Next word value
  logic vld_q; // Offer under way
  logic take;
  assign take = (trace_valid && trace_ready) || (sys_valid && sys_ready);
  assign trace_valid = vld_q;
  assign sys_valid = vld_q;
  // Idle data is inverted so a stale word never matches by chance
  assign trace_data = vld_q ? cnt_q : ~cnt_q;
  assign sys_data = trace_data;
  assign offchip_ready = !stall;
  // An offer is held until taken
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= 32'h00000000;
      vld_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + {31'h00000000, take};
      vld_q <= go || (vld_q && !take);
    end
  end
endmodule : tfc_trace_partner

// ### sim/tfc_regs_tb.sv
// Self-checking bench for the trace funnel register bank.
// Assumes the bound checker and the trace partner model.
`timescale 1ns/100ps
`include "tfc_consts.svh"
module tfc_regs_tb;
  logic ref_clk, arst_n, go, stall;
  logic [19:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, trace_data, sys_data, offchip_data, r, v, oexp, base;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic trace_valid, trace_ready, sys_valid, sys_ready, offchip_valid, offchip_ready;
  logic [33:0] rq[$]; // Expected {resp, data} per read
  logic [1:0] bq[$]; // Expected write responses
  logic [19:0] ra[3] = '{`TFC_OFF_CONFIG, `TFC_OFF_STUSER, `TFC_OFF_STENABLE};
  localparam logic [19:0] ctl = `TFC_OFF_CONTROL;
  int n_fail, tests_run, seed, i;
  // Small memory so a fill is quick
  tfc_regs #(.DEPTH(8)) tfc_regs_inst (.*);
  tfc_trace_partner tfc_trace_partner_inst (.*);
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [19:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    bq.push_back(e);
    // No cycle count assumed; only the watchdog ends a hang
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [19:0] a, input logic [33:0] e);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    rq.push_back(e);
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  // Result watcher: oldest note against what appears
  always @(posedge ref_clk)
  begin
    r = $random(seed);
    stall <= r[0];
    if (s_axi_rvalid && s_axi_rready) chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
    if (offchip_valid && offchip_ready)
    begin
      chk("offchip", {2'h0, oexp}, {2'h0, offchip_data});
      oexp = oexp + 32'h1;
    end
  end
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Watchdog well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    test_done;
  end
  initial
  begin
    {arst_n, go, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    seed = 70210;
    oexp = 32'h0;
    n_fail = 0;
    tests_run = 0;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(ctl, 34'h000080000);
    rd(`TFC_OFF_WRPTR, 34'h0);
    wr(`TFC_OFF_RDPTR, 32'h00000005, 2'h0);
    rd(`TFC_OFF_RDPTR, 34'h5);
    foreach (ra[k])
    begin
      v = $random(seed);
      wr(ra[k], v, 2'h0);
      rd(ra[k], {2'h0, v});
    end
    rd(20'h3F104, {2'h2, 32'h0});
    wr(20'h3F104, 32'hFFFFFFFF, 2'h2);
    wr(ctl, 32'h00060301, 2'h0);
    rd(ctl, 34'h000080000);
    wr(ctl, 32'h80060000, 2'h0);
    rd(ctl, 34'h0000E0000);
    wr(ctl, 32'h80040000, 2'h0);
    rd(ctl, 34'h0000E0000);
    wr(ctl, 32'h80000000, 2'h0);
    rd(ctl, 34'h0000E0000);
    wr(ctl, 32'h80020000, 2'h0);
    rd(ctl, 34'h0000A0000);
    wr(ctl, 32'hFFFFFFFF, 2'h0);
    rd(ctl, 34'h0001E0303);
    // Off-chip stream with both sources and a stalling port
    wr(ctl, 32'h80160003, 2'h0);
    go <= 1'b1;
    repeat (60) @(posedge ref_clk);
    go <= 1'b0;
    repeat (30) @(posedge ref_clk);
    rd(ctl, 34'h0001E0003);
    // A half-stalled port costs about three cycles a word
    chk("traffic", 34'h1, {33'h0, oexp > 32'hA});
    // On-chip fill until full, then read the memory back
    wr(ctl, 32'h80068100, 2'h0);
    base = oexp;
    wr(ctl, 32'h80060101, 2'h0);
    go <= 1'b1;
    repeat (30) @(posedge ref_clk);
    rd(ctl, 34'h0000E4101);
    wr(`TFC_OFF_RDPTR, 32'h00000003, 2'h0);
    wr(ctl, 32'h80070101, 2'h0);
    repeat (20) @(posedge ref_clk);
    for (i = 0; i < 8; i++)
      rd(`TFC_OFF_DATA0 + 20'(8 * i), {2'h0, base + 32'((i + 3) % 8)});
    wr(ctl, 32'h80068000, 2'h0);
    rd(ctl, 34'h0000E0000);
    rd(`TFC_OFF_WRPTR, 34'h0);
    // Let the watcher score the last answer before the verdict
    @(posedge ref_clk);
    test_done;
  end
endmodule : tfc_regs_tb
